// >>> tdsw_cfg.svh
// Constants for the transmit status writeback block: field positions, register offsets, reset values.
// Assumes inclusion by bare name from the package and the design module.
`ifndef TDSW_CFG_SVH
`define TDSW_CFG_SVH

// Transmit status word field positions.
`define TDSW_OWN_BIT 31
`define TDSW_TIMER_HI 29
`define TDSW_TIMER_LO 16
`define TDSW_ES_BIT 15
`define TDSW_TO_BIT 14
`define TDSW_MBZ_BIT 13
`define TDSW_LE_BIT 12
`define TDSW_LO_BIT 11
`define TDSW_NC_BIT 10
`define TDSW_LC_BIT 9
`define TDSW_EC_BIT 8
`define TDSW_HF_BIT 7
`define TDSW_CC_HI 6
`define TDSW_CC_LO 3
`define TDSW_TN_BIT 2
`define TDSW_UF_BIT 1
`define TDSW_DE_BIT 0

// Collisions that abort a frame.
`define TDSW_MAX_COLL 5'h10
// Operating mode value that selects internal loopback.
`define TDSW_MODE_LOOP 2'h1

// APB register byte offsets.
`define TDSW_ADDR_CTRL 8'h00
`define TDSW_ADDR_STAT 8'h04
`define TDSW_ADDR_MASK 8'h08
`define TDSW_ADDR_WORD 8'h0C

// Control register fields.
`define TDSW_CTRL_START 0
`define TDSW_CTRL_MODE_LO 1
`define TDSW_CTRL_MODE_HI 2

// Controller status register interrupt bits.
`define TDSW_INT_TI 0
`define TDSW_INT_TW 1
`define TDSW_INT_WB 2
`define TDSW_INT_W 3
`define TDSW_STATE_LO 8

// Reset values.
`define TDSW_RST_MASK 3'h0
`define TDSW_RST_MODE 2'h0

`endif

// >>> tdsw_pkg.sv
// Types shared by the transmit status writeback block.
// Assumes tdsw_cfg.svh is on the include path.
`include "tdsw_cfg.svh"

package tdsw_pkg;

  // Transmit process states, one-hot.
  typedef enum logic [2:0] {
    TDSW_RUN = 3'h1,
    TDSW_SUSPEND = 3'h2,
    TDSW_STOP = 3'h4
  } tdsw_state_t;

  // Per-cycle outcome pulses from the medium access logic.
  typedef struct packed {
    logic frame_end;
    logic fifo_underflow;
    logic late_collision;
    logic carrier_dropped;
    logic carrier_absent;
    logic heartbeat_fail;
    logic postponed;
    logic babble;
    logic collision;
    logic [13:0] bit_time;
  } tdsw_mac_t;

  // Descriptor presented by the fetch logic, one-cycle valid.
  typedef struct packed {
    logic valid;
    logic possession_flag;
    logic zero_length;
    logic [1:0] data_type_field;
    logic first_segment_flag;
    logic last_segment_flag;
    logic virtual_addr_flag;
  } tdsw_desc_t;

endpackage

// >>> tdsw_writeback.sv
// Transmit status word generator with APB control, interrupt status and writeback handshake.
// Assumes MAC and descriptor-fetch pulses come from logic on the same clock.
//
// Implementation choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "tdsw_cfg.svh"

module tdsw_writeback (
  input wire logic clock,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire tdsw_pkg::tdsw_mac_t mac,
  input wire tdsw_pkg::tdsw_desc_t desc,
  input wire logic xlat_fail,
  output logic [31:0] wb_word,
  output logic wb_valid,
  input wire logic wb_ready,
  output logic tx_abort,
  output logic xlat_req,
  output logic [2:0] tx_state,
  output logic irq
);

  //////////////////////////////////////////////////////////////////////////////
  // Declarations.

  tdsw_pkg::tdsw_state_t state; // Transmit process state.
  logic [1:0] mode; // Operating mode field.
  logic [2:0] int_stat; // Sticky interrupt flags.
  logic [2:0] int_mask; // Interrupt enables, same layout.
  logic in_frame; // A chained frame is open.
  logic [4:0] coll_cnt; // Collisions on the current frame.
  logic [13:0] timer_cap; // Bit time captured at the aborting collision.
  logic [11:0] acc; // Accumulated error flags for status word bits 14, 12..7 and 2..0.
  logic [11:0] next_acc; // Flags including this cycle's pulses.
  logic [31:0] next_word; // Word to be written back.
  logic running; // Events are accepted.
  logic ec_hit; // Sixteenth collision this cycle.
  logic le_hit; // Chain fault this cycle.
  logic tn_hit; // Translation fault this cycle.
  logic close; // Word is composed and handed out this cycle.
  logic suspend_ev; // Error that suspends transmission.
  logic stop_ev; // Error that stops transmission.
  logic apb_access; // APB access phase completes this edge.
  logic apb_read_stat; // Read of the status register completes.
  logic start_req; // Software asks the transmitter to run.

  // Index of each accumulated flag.
  localparam int A_TO = 0;
  localparam int A_LE = 1;
  localparam int A_LO = 2;
  localparam int A_NC = 3;
  localparam int A_LC = 4;
  localparam int A_EC = 5;
  localparam int A_HF = 6;
  localparam int A_TN = 7;
  localparam int A_UF = 8;
  localparam int A_DE = 9;

  //////////////////////////////////////////////////////////////////////////////
  // Event decode.

  // Only a running transmitter listens to the MAC and the fetch logic.
  assign running = (state == tdsw_pkg::TDSW_RUN) && !wb_valid;

  // Host-owned, empty or non-data descriptors inside an open chain are faults,
  // as is a first segment inside a frame or a continuation outside one.
  always_comb begin
    le_hit = 1'b0;
    if (running && desc.valid) begin
      if (in_frame && (!desc.possession_flag || desc.zero_length || desc.data_type_field != 2'h0)) begin
        le_hit = 1'b1;
      end else if (desc.possession_flag && (desc.first_segment_flag == in_frame)) begin
        le_hit = 1'b1;
      end
    end
  end

  // A translation fault counts only when the pointer was virtual.
  assign tn_hit = running && xlat_fail && in_frame && xlat_req;

  // The sixteenth collision of a frame aborts it.
  assign ec_hit = running && mac.collision && (coll_cnt == `TDSW_MAX_COLL - 5'h01);

  assign suspend_ev = le_hit || tn_hit || (running && mac.fifo_underflow);
  assign stop_ev = running && mac.babble;

  // A frame closes at its natural end or at any aborting error.
  assign close = running && (in_frame || le_hit) &&
    (mac.frame_end || suspend_ev || stop_ev || ec_hit || mac.late_collision);

  //////////////////////////////////////////////////////////////////////////////
  // Word assembly.

  // Merge this cycle's pulses into the flags so the closing cycle is not lost.
  always_comb begin
    next_acc = acc;
    if (running) begin
      next_acc[A_TO] = acc[A_TO] | mac.babble;
      next_acc[A_LE] = acc[A_LE] | le_hit;
      next_acc[A_LO] = acc[A_LO] | mac.carrier_dropped;
      next_acc[A_NC] = acc[A_NC] | mac.carrier_absent;
      next_acc[A_LC] = acc[A_LC] | mac.late_collision;
      next_acc[A_EC] = acc[A_EC] | ec_hit;
      next_acc[A_HF] = acc[A_HF] | mac.heartbeat_fail;
      next_acc[A_TN] = acc[A_TN] | tn_hit;
      next_acc[A_UF] = acc[A_UF] | mac.fifo_underflow;
      next_acc[A_DE] = acc[A_DE] | mac.postponed;
    end
    // Carrier flags mean nothing in loopback, so they are written clear there.
    if (mode == `TDSW_MODE_LOOP) begin
      next_acc[A_LO] = 1'b0;
      next_acc[A_NC] = 1'b0;
    end
  end

  // The whole status word, with ownership cleared, is built in one piece.
  always_comb begin
    next_word = 32'h0;
    next_word[`TDSW_OWN_BIT] = 1'b0;
    if (next_acc[A_EC]) begin
      next_word[`TDSW_TIMER_HI:`TDSW_TIMER_LO] = ec_hit ? mac.bit_time : timer_cap;
    end
    next_word[`TDSW_ES_BIT] = next_acc[A_UF] | next_acc[A_TN] | next_acc[A_EC] | next_acc[A_LC] |
      next_acc[A_NC] | next_acc[A_LO] | next_acc[A_LE] | next_acc[A_TO];
    next_word[`TDSW_TO_BIT] = next_acc[A_TO];
    next_word[`TDSW_MBZ_BIT] = 1'b0;
    next_word[`TDSW_LE_BIT] = next_acc[A_LE];
    next_word[`TDSW_LO_BIT] = next_acc[A_LO];
    next_word[`TDSW_NC_BIT] = next_acc[A_NC];
    next_word[`TDSW_LC_BIT] = next_acc[A_LC];
    next_word[`TDSW_EC_BIT] = next_acc[A_EC];
    next_word[`TDSW_HF_BIT] = next_acc[A_HF];
    // The tally counts prior collisions plus this cycle's; it wraps meaninglessly on sixteen.
    next_word[`TDSW_CC_HI:`TDSW_CC_LO] = coll_cnt[3:0] + {3'h0, running & mac.collision};
    next_word[`TDSW_TN_BIT] = next_acc[A_TN];
    next_word[`TDSW_UF_BIT] = next_acc[A_UF];
    next_word[`TDSW_DE_BIT] = next_acc[A_DE];
  end

  //////////////////////////////////////////////////////////////////////////////
  // Frame tracking.

  // Flags and collision count live for one frame; the captured timer is not cleared at close.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      acc <= 12'h000;
      coll_cnt <= 5'h00;
      timer_cap <= 14'h0000;
      in_frame <= 1'b0;
      xlat_req <= 1'b0;
    end else if (close) begin
      acc <= 12'h000;
      coll_cnt <= 5'h00;
      in_frame <= 1'b0;
      xlat_req <= 1'b0;
    end else if (running) begin
      acc <= next_acc;
      if (mac.collision) begin
        coll_cnt <= coll_cnt + 5'h01;
      end
      if (ec_hit) begin
        timer_cap <= mac.bit_time;
      end
      // Host-owned descriptors outside a frame are left alone.
      if (desc.valid && desc.possession_flag && desc.first_segment_flag) begin
        in_frame <= 1'b1;
      end
      // The pointer word is translated only when flagged virtual.
      if (desc.valid && desc.possession_flag) begin
        xlat_req <= desc.virtual_addr_flag;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Writeback handshake.

  // One write carries ownership and every status field together; the word
  // holds until the memory side accepts it, which also stalls new events.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      wb_valid <= 1'b0;
      wb_word <= 32'h0000_0000;
    end else if (close) begin
      wb_valid <= 1'b1;
      wb_word <= next_word;
    end else if (wb_valid && wb_ready) begin
      wb_valid <= 1'b0;
    end
  end

  // Abort strobe to the MAC for every error that truncates the frame.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      tx_abort <= 1'b0;
    end else begin
      tx_abort <= suspend_ev || stop_ev || ec_hit || (running && mac.late_collision);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Transmit process state.

  assign start_req = apb_access && pwrite && (paddr == `TDSW_ADDR_CTRL) && pwdata[`TDSW_CTRL_START];

  // Stop outranks suspend; software start resumes from either.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      state <= tdsw_pkg::TDSW_STOP;
    end else begin
      case (state)
        tdsw_pkg::TDSW_RUN: begin
          if (stop_ev) begin
            state <= tdsw_pkg::TDSW_STOP;
          end else if (suspend_ev) begin
            state <= tdsw_pkg::TDSW_SUSPEND;
          end
        end
        tdsw_pkg::TDSW_SUSPEND, tdsw_pkg::TDSW_STOP: begin
          if (start_req) begin
            state <= tdsw_pkg::TDSW_RUN;
          end
        end
        default: begin
          state <= tdsw_pkg::TDSW_STOP;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      tx_state <= 3'h4;
    end else begin
      tx_state <= 3'(state);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Interrupt flags.

  // Set wins over the clearing read, so an event in that cycle survives.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      int_stat <= 3'h0;
    end else begin
      int_stat <= (apb_read_stat ? 3'h0 : int_stat) |
        {close, stop_ev, suspend_ev};
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(int_stat & int_mask);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // APB slave: one wait-free access phase, answer registered in setup.

  assign apb_access = psel && penable && pready;
  assign apb_read_stat = apb_access && !pwrite && (paddr == `TDSW_ADDR_STAT);

  // Control and mask writes.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      mode <= `TDSW_RST_MODE;
      int_mask <= `TDSW_RST_MASK;
    end else if (apb_access && pwrite) begin
      if (paddr == `TDSW_ADDR_CTRL) begin
        mode <= pwdata[`TDSW_CTRL_MODE_HI:`TDSW_CTRL_MODE_LO];
      end else if (paddr == `TDSW_ADDR_MASK) begin
        int_mask <= pwdata[2:0];
      end
    end
  end

  // Read data and error are latched in the setup cycle, ready one cycle later.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      pready <= 1'b1;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      if (paddr == `TDSW_ADDR_CTRL) begin
        prdata <= {29'h0, mode, 1'b0};
      end else if (paddr == `TDSW_ADDR_STAT) begin
        prdata <= {21'h0, 3'(state), 5'h0, int_stat};
      end else if (paddr == `TDSW_ADDR_MASK) begin
        prdata <= {29'h0, int_mask};
      end else if (paddr == `TDSW_ADDR_WORD) begin
        prdata <= wb_word;
      end else begin
        pslverr <= 1'b1;
      end
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// >>> tdsw_properties.sv
// Checker holding the port assertions of the transmit status writeback block.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module tdsw_properties (
  input wire logic clock,
  input wire logic nrst,
  input wire tdsw_pkg::tdsw_mac_t mac,
  input wire logic xlat_fail,
  input wire logic [31:0] wb_word,
  input wire logic wb_valid,
  input wire logic wb_ready,
  input wire logic tx_abort,
  input wire logic xlat_req,
  input wire logic [2:0] tx_state,
  input wire logic irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  // Events count only while running with no word pending, so gate every event-triggered antecedent.
  logic idle_run;
  assign idle_run = (tx_state == 3'h1) && !wb_valid;
  ////////////////////////////////////////////////////////////
  a_owner_returned: assert property (wb_valid |-> !wb_word[31])
    else $error("returned word still owned");
  a_rollup_or: assert property (wb_valid |-> (wb_word[15] == |(wb_word & 32'h0000_5F06)))
    else $error("error summary mismatch");
  a_zero_bit: assert property (wb_valid |-> !wb_word[13])
    else $error("bit 13 written as one");
  a_babble_stops: assert property (idle_run && mac.babble |-> ##[1:2] (wb_word[14] && tx_state == 3'h4))
    else $error("babble did not stop the transmitter");
  a_underflow_suspends: assert property (idle_run && mac.fifo_underflow |-> ##[1:2] (wb_word[1] && tx_state == 3'h2))
    else $error("underflow did not suspend");
  a_late_abort: assert property (idle_run && mac.late_collision |-> ##[1:2] (wb_valid && wb_word[9]))
    else $error("late collision not reported");
  a_xlat_suspends: assert property (idle_run && xlat_fail && xlat_req |-> ##[1:2] (wb_word[2] && tx_state == 3'h2))
    else $error("translation fault did not suspend");
  // The state port is registered once more than the word, so it settles one cycle after the word.
  a_length_suspends: assert property ($rose(wb_valid) && wb_word[12] |=> tx_state == 3'h2)
    else $error("length error did not suspend");
  a_word_holds: assert property (wb_valid && !wb_ready |=> wb_valid && $stable(wb_word))
    else $error("status word changed before acceptance");
  // Underflow, babble and late collision must strobe the abort line on the very next cycle.
  a_abort_strobe: assert property (idle_run && (mac.fifo_underflow || mac.babble || mac.late_collision) |=> tx_abort)
    else $error("truncating error gave no abort strobe");
  // Main scenarios: a handover, an abort and an interrupt.
  c_handover: cover property (wb_valid && wb_ready);
  c_abort: cover property (tx_abort);
  c_irq: cover property (irq);
endmodule
bind tdsw_writeback tdsw_properties u_props (.clock(clock), .nrst(nrst), .mac(mac), .xlat_fail(xlat_fail),
  .wb_word(wb_word), .wb_valid(wb_valid), .wb_ready(wb_ready), .tx_abort(tx_abort), .xlat_req(xlat_req),
  .tx_state(tx_state), .irq(irq));
`default_nettype wire

// >>> tdsw_host_model.sv
// Host memory side: accepts written-back status words, promptly or slowly.
// Assumes the same clock and reset as the block.
`timescale 1ns/1ps
`default_nettype none
module tdsw_host_model (
  input wire logic clock,
  input wire logic nrst,
  input wire logic slow,
  input wire logic [31:0] wb_word,
  input wire logic wb_valid,
  output logic wb_ready,
  output logic got,
  output logic [31:0] word
);
  logic [1:0] wait_q; // Stall counter used in slow mode.
  // Ready rises only for a pending word; a slow host stalls three cycles first.
  always_ff @(posedge clock) begin
    if (!nrst) begin
      wb_ready <= 1'h0;
      got <= 1'h0;
      word <= 32'h0;
      wait_q <= 2'h0;
    end else begin
      got <= wb_valid && wb_ready;
      if (wb_valid && wb_ready) begin
        word <= wb_word;
        wb_ready <= 1'h0;
        wait_q <= 2'h0;
      end else if (wb_valid) begin
        wb_ready <= !slow || wait_q == 2'h3;
        wait_q <= wait_q + 2'h1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> test_tdsw_writeback.sv
// Testbench: random frames, error corners, chain faults and translation faults.
// Assumes the package, host model and checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module test_tdsw_writeback;
  logic clock = 1'h0;
  logic nrst = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic xlat_fail = 1'h0;
  logic slow = 1'h0;
  logic [31:0] prdata, wb_word, word;
  logic pready, pslverr, wb_valid, wb_ready, tx_abort, xlat_req, irq, got;
  logic [2:0] tx_state;
  tdsw_pkg::tdsw_mac_t mac = '0;
  tdsw_pkg::tdsw_desc_t desc = '0;
  logic [1:0] mode = 2'h0;
  logic [2:0] mask = 3'h0;
  logic [13:0] bt = 14'h0;
  int bad_count = 0;
  int num_checks = 0;
  // Corner tables: second descriptors of faulty chains, and the error cases.
  logic [7:0] second [5] = '{8'hC4, 8'h82, 8'hE2, 8'hD2, 8'hDA};
  logic [31:0] ferr [4] = '{32'h2, 32'h200, 32'h4000, 32'h100};
  logic [2:0] serr [4] = '{3'h2, 3'h1, 3'h4, 3'h1};
  logic [2:0] ierr [4] = '{3'h5, 3'h4, 3'h6, 3'h4};
  tdsw_writeback DUT (.clock(clock), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .mac(mac),
    .desc(desc), .xlat_fail(xlat_fail), .wb_word(wb_word), .wb_valid(wb_valid), .wb_ready(wb_ready),
    .tx_abort(tx_abort), .xlat_req(xlat_req), .tx_state(tx_state), .irq(irq));
  tdsw_host_model host (.clock(clock), .nrst(nrst), .slow(slow), .wb_word(wb_word),
    .wb_valid(wb_valid), .wb_ready(wb_ready), .got(got), .word(word));
  ////////////////////////////////////////////////////////////
  task automatic finish_test;
    $display("Checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string s, input logic [31:0] x, input logic [31:0] g);
    num_checks++;
    if (g !== x) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", s, x, g);
    end
  endtask
  // One APB transfer; every call starts on a fresh edge so no signal is set twice in a step.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
    output logic e);
    int n;
    @(posedge clock);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'h1 && n < 50);
    if (n >= 50) bad_count++;
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic rd(input string s, input logic [7:0] a, input logic [31:0] m, input logic [31:0] x,
    input logic xe);
    logic [31:0] q;
    logic e;
    apb(1'h0, a, 32'h0, q, e);
    chk(s, x, q & m);
    chk(s, {31'h0, xe}, {31'h0, e});
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'h1, a, d, q, e);
  endtask
  // Single-cycle pulses; the bit-time level stays put between them.
  task automatic pulse(input tdsw_pkg::tdsw_mac_t m);
    tdsw_pkg::tdsw_mac_t z;
    z = '0;
    z.bit_time = bt;
    m.bit_time = bt;
    @(posedge clock);
    mac <= m;
    @(posedge clock);
    mac <= z;
  endtask
  task automatic hits(input int n);
    tdsw_pkg::tdsw_mac_t m;
    m = '0;
    m.collision = 1'h1;
    repeat (n) pulse(m);
  endtask
  task automatic give(input logic [7:0] d);
    @(posedge clock);
    desc <= tdsw_pkg::tdsw_desc_t'(d);
    @(posedge clock);
    desc <= '0;
  endtask
  // Waits for the handover, checks word, state, interrupt and read-clear, then restarts if halted.
  task automatic close(input logic [31:0] f, input logic [3:0] cc, input logic [2:0] st, input logic [2:0] ints);
    logic [31:0] x, m;
    int n;
    x = f | {25'h0, cc, 3'h0} | {2'h0, bt, 16'h0} | {16'h0, |(f & 32'h0000_5F06), 15'h0};
    m = f[8] ? 32'hFFFF_FF87 : 32'hC000_FFFF;
    n = 0;
    while (got !== 1'h1 && n < 300) begin
      @(posedge clock);
      n++;
    end
    if (n >= 300) bad_count++;
    chk("status word", x & m, word & m);
    chk("state", {29'h0, st}, {29'h0, tx_state});
    repeat (2) @(posedge clock);
    chk("irq", {31'h0, |(ints & mask)}, {31'h0, irq});
    rd("word reg", 8'h0C, m, x & m, 1'h0);
    rd("status reg", 8'h04, 32'h0000_0707, {21'h0, st, 5'h0, ints}, 1'h0);
    repeat (2) @(posedge clock);
    chk("irq clear", 32'h0, {31'h0, irq});
    if (st != 3'h1) wr(8'h00, {29'h0, mode, 1'h1});
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    forever #12.5 clock = ~clock;
  end
  // Watchdog: the whole run needs under a thousand cycles.
  initial begin
    #(25 * 30000);
    bad_count++;
    finish_test();
  end
  initial begin
    tdsw_pkg::tdsw_mac_t m;
    logic [3:0] p;
    int c;
    void'($urandom(51102));
    repeat (8) @(posedge clock);
    nrst <= 1'h1;
    chk("reset state", 32'h4, {29'h0, tx_state});
    rd("mask reset", 8'h08, 32'h7, 32'h0, 1'h0);
    rd("stat reset", 8'h04, 32'h707, 32'h400, 1'h0);
    rd("unmapped", 8'h10, 32'hFFFF_FFFF, 32'h0, 1'h1);
    $display("Test reset done");
    // Random good frames; loopback drops the carrier bits, mask 0 keeps irq low.
    for (int i = 0; i < 8; i++) begin
      mode = (i == 2) ? 2'h1 : {1'h0, 1'($urandom)};
      mask = (i == 0) ? 3'h0 : 3'($urandom_range(7, 1));
      slow <= 1'($urandom);
      bt = 14'($urandom);
      p = 4'($urandom);
      c = $urandom_range(15, 0);
      wr(8'h08, {29'h0, mask});
      wr(8'h00, {29'h0, mode, 1'h1});
      give(8'hC6);
      hits(c);
      m = '0;
      m.carrier_dropped = p[0];
      m.carrier_absent = p[1];
      m.heartbeat_fail = p[2];
      m.postponed = p[3];
      pulse(m);
      m = '0;
      m.frame_end = 1'h1;
      pulse(m);
      close({20'h0, p[0] && mode != 2'h1, p[1] && mode != 2'h1, 2'h0, p[2], 6'h0, p[3]}, 4'(c), 3'h1, 3'h4);
    end
    $display("Test random frames done");
    mask = 3'h7;
    wr(8'h08, 32'h7);
    // Underflow, late collision, babble and sixteen collisions.
    for (int k = 0; k < 4; k++) begin
      c = (k == 3) ? 16 : $urandom_range(15, 0);
      give(8'hC6);
      hits(c);
      m = '0;
      m.fifo_underflow = (k == 0);
      m.late_collision = (k == 1);
      m.babble = (k == 2);
      if (k != 3) pulse(m);
      close(ferr[k], 4'(c), serr[k], ierr[k]);
    end
    $display("Test error cases done");
    // Broken chains: repeated first, host-owned, zero length, data types 2 and 3, orphan segment.
    for (int k = 0; k < 6; k++) begin
      if (k < 5) give(8'hC4);
      give(k < 5 ? second[k] : 8'hC2);
      close(32'h1000, 4'h0, 3'h2, 3'h5);
    end
    $display("Test chain faults done");
    give(8'hC7);
    repeat (2) @(posedge clock);
    chk("xlat req", 32'h1, {31'h0, xlat_req});
    @(posedge clock);
    xlat_fail <= 1'h1;
    @(posedge clock);
    xlat_fail <= 1'h0;
    close(32'h4, 4'h0, 3'h2, 3'h5);
    $display("Test translation fault done");
    finish_test();
  end
endmodule
`default_nettype wire
